// ---- src/gsf_top.sv ----
// measurement sequencer, fault reporter and recorder output
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
//
// How it works
// - each cycle starts with configurable pump purge
// - configurable settling wait follows the purge
// - result is mean of many acoustic samples
// - result normalized to reference temperature, pressure
// - two thresholds drive alarms, direction configurable
// - failure sends code on uart, sets alarm
// - after failure halt until power cycle
// - code B when ir source draws nothing
// - code C when chopper blocked or still
// - code D when ambient below 10 or above 40
// - code E when zero adjustment cannot settle
// - code I when cell above 55 degrees
// - code L when stored configuration is corrupt
// - external mode needs start before requests count
// - recorder held at base level (4 ma, or 0 v in voltage mode) during warmup, zero
// - recorder updated once at the start of each pump cycle that follows a result
// - underflow clamps recorder to lower range limit
// - full range scaled linearly onto output span
// - count consecutive zero hits, fail after 50 tries
// - unit ready low until regular measuring begins
module gsf_top
   import gsf_pkg::*;
#(
   parameter int unsigned PURGE_DEF  = PURGE_CYC,
   parameter int unsigned SETTLE_DEF = SETTLE_CYC
)(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // sensor front end
   input  wire logic        sample_vld,
   input  wire logic [15:0] sample,
   input  wire gsf_env_t    env,
   input  wire gsf_health_t health,
   // plant controller
   input  wire logic        start,
   input  wire logic        meas_req,
   input  wire logic        zero_req,
   output logic             unit_ready,
   output logic             alarm1,
   output logic             alarm2,
   output logic             fault_alarm,
   // actuators, recorder and uart
   output logic             pump_on,
   output logic [15:0]      rec_value,
   output logic             uart_tx
);

   ////////////////////////////////////////////////////////////////////////////
   // register file

   logic [4:0]   ctrl_ff;
   logic [31:0]  purge_ff;
   logic [31:0]  settle_ff;
   logic [15:0]  thr1_ff;
   logic [15:0]  thr2_ff;
   logic [15:0]  range_ff;
   logic [15:0]  ztol_ff;
   logic         ack_ff;
   logic [31:0]  rdat_ff;
   logic [15:0]  result_ff;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  sel);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            m[i*8 +: 8] = dat[i*8 +: 8];
      return m;
   endfunction

   wire          bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
   wire          bus_wr  = bus_req & wb_we_i;
   wire          wr_ctrl = bus_wr && wb_adr_i == OFS_CTRL;
   wire          wr_prg  = bus_wr && wb_adr_i == OFS_PURGE;
   wire          wr_stl  = bus_wr && wb_adr_i == OFS_SETTLE;
   wire          wr_thr1 = bus_wr && wb_adr_i == OFS_THR1;
   wire          wr_thr2 = bus_wr && wb_adr_i == OFS_THR2;
   wire          wr_rng  = bus_wr && wb_adr_i == OFS_RANGE;
   wire          wr_ztol = bus_wr && wb_adr_i == OFS_ZTOL;

   wire [31:0]   m_ctrl = merge({27'h0, ctrl_ff}, wb_dat_i, wb_sel_i);
   wire [31:0]   m_prg  = merge(purge_ff, wb_dat_i, wb_sel_i);
   wire [31:0]   m_stl  = merge(settle_ff, wb_dat_i, wb_sel_i);
   wire [31:0]   m_thr1 = merge({16'h0, thr1_ff}, wb_dat_i, wb_sel_i);
   wire [31:0]   m_thr2 = merge({16'h0, thr2_ff}, wb_dat_i, wb_sel_i);
   wire [31:0]   m_rng  = merge({16'h0, range_ff}, wb_dat_i, wb_sel_i);
   wire [31:0]   m_ztol = merge({16'h0, ztol_ff}, wb_dat_i, wb_sel_i);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ctrl_ff   <= CTRL_RST;
         purge_ff  <= PURGE_DEF;
         settle_ff <= SETTLE_DEF;
         thr1_ff   <= THR_RST;
         thr2_ff   <= THR_RST;
         range_ff  <= RANGE_RST;
         ztol_ff   <= ZTOL_RST;
      end
      else
      begin
         if (wr_ctrl) ctrl_ff   <= m_ctrl[4:0];
         if (wr_prg)  purge_ff  <= m_prg;
         if (wr_stl)  settle_ff <= m_stl;
         if (wr_thr1) thr1_ff   <= m_thr1[15:0];
         if (wr_thr2) thr2_ff   <= m_thr2[15:0];
         if (wr_rng)  range_ff  <= m_rng[15:0];
         if (wr_ztol) ztol_ff   <= m_ztol[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer state

   gsf_state_t   state_ff;
   gsf_state_t   nxt_state;
   logic [31:0]  tmr_ff;
   logic [5:0]   cnt_ff;
   logic [21:0]  acc_ff;
   logic [5:0]   zhit_ff;
   logic [5:0]   ztry_ff;
   logic [15:0]  zero_ff;
   logic [15:0]  raw_ff;
   logic [7:0]   code_ff;
   logic         have_res_ff;
   logic         ready_ff;

   wire          ext_mode = ctrl_ff[CTRL_EXT];
   // requests are dead while the controller has not raised start
   wire          req_ok   = ~ext_mode | (meas_req & start);
   wire          src_on   = state_ff inside {ST_ZERO, ST_PURGE, ST_SETTLE,
                                             ST_MEASURE, ST_COMPARE};
   wire          tmr_done = tmr_ff == 32'h0;

   // zero adjustment: consecutive in-tolerance hits, bounded tries
   wire          z_in_tol = sample <= ztol_ff;
   wire          z_accept = sample_vld & z_in_tol
                            & (zhit_ff == ZERO_NEED - 6'h01);
   wire          z_fail   = state_ff == ST_ZERO & sample_vld & ~z_accept
                            & (ztry_ff == ZERO_TRIES - 6'h01);

   // only the first detected cause is reported
   wire [7:0]    fault_code =
      !health.cfg_ok                  ? CODE_L :
      (src_on & !health.ir_power_ok)  ? CODE_B :
      (src_on & !health.chopper_ok)   ? CODE_C :
      (env.amb_c < AMB_MIN_C ||
       env.amb_c > AMB_MAX_C)         ? CODE_D :
      (env.cell_c > CELL_MAX_C)       ? CODE_I :
      z_fail                          ? CODE_E :
                                        CODE_NONE;
   wire          fault_now = fault_code != CODE_NONE;
   wire          last_smp  = sample_vld & (cnt_ff == AVG_LAST);

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_SELFTEST: nxt_state = ST_WARMUP;
         ST_WARMUP:   if (health.warmup_done) nxt_state = ST_ZERO;
         ST_ZERO:     if (z_accept) nxt_state = ST_STANDBY;
         ST_STANDBY:
            if (zero_req)    nxt_state = ST_ZERO;
            else if (req_ok) nxt_state = ST_PURGE;
         ST_PURGE:    if (tmr_done) nxt_state = ST_SETTLE;
         ST_SETTLE:   if (tmr_done) nxt_state = ST_MEASURE;
         ST_MEASURE:  if (last_smp) nxt_state = ST_COMPARE;
         ST_COMPARE:
            if (zero_req)    nxt_state = ST_ZERO;
            else if (req_ok) nxt_state = ST_PURGE;
            else             nxt_state = ST_STANDBY;
         ST_HALT:     nxt_state = ST_HALT;
         default:     nxt_state = ST_HALT;
      endcase
      if (fault_now && state_ff != ST_HALT)
         nxt_state = ST_HALT;
   end

   wire          enter_purge = nxt_state == ST_PURGE
                               && state_ff != ST_PURGE;
   wire          enter_halt  = nxt_state == ST_HALT
                               && state_ff != ST_HALT;
   wire [31:0]   nxt_tmr = enter_purge                  ? purge_ff :
                           (state_ff == ST_PURGE &&
                            tmr_done)                   ? settle_ff :
                           tmr_done                     ? tmr_ff :
                                                          tmr_ff - 32'h1;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_SELFTEST;
         tmr_ff   <= 32'h0;
         code_ff  <= CODE_NONE;
      end
      else
      begin
         state_ff <= nxt_state;
         tmr_ff   <= nxt_tmr;
         if (enter_halt)
            code_ff <= fault_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // averaging and zero offset

   wire [21:0]   acc_sum  = acc_ff + {6'h0, sample};
   wire [15:0]   avg      = acc_sum[AVG_LOG2 +: 16];
   // underflow below the zero offset reads as zero concentration
   wire [15:0]   nxt_raw  = avg > zero_ff ? avg - zero_ff : 16'h0;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cnt_ff <= 6'h0;
         acc_ff <= 22'h0;
         raw_ff <= 16'h0;
      end
      else if (state_ff != ST_MEASURE)
      begin
         cnt_ff <= 6'h0;
         acc_ff <= 22'h0;
      end
      else if (sample_vld)
      begin
         cnt_ff <= cnt_ff + 6'h1;
         acc_ff <= acc_sum;
         if (cnt_ff == AVG_LAST)
            raw_ff <= nxt_raw;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         zhit_ff <= 6'h0;
         ztry_ff <= 6'h0;
         zero_ff <= 16'h0;
      end
      else if (state_ff != ST_ZERO)
      begin
         zhit_ff <= 6'h0;
         ztry_ff <= 6'h0;
      end
      else if (sample_vld)
      begin
         zhit_ff <= z_in_tol ? zhit_ff + 6'h1 : 6'h0;
         ztry_ff <= ztry_ff + 6'h1;
         if (z_accept)
            zero_ff <= sample;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // normalization, alarms, recorder scaling

   // a wide divider is traded for one compare cycle per measurement
   wire [38:0]   norm_num = 39'(raw_ff) * 39'(env.gas_k10)
                            * 39'(P_REF_MBAR);
   wire [22:0]   norm_den = 23'(T_REF_K10) * 23'(env.pres_mbar);
   wire [38:0]   norm_q   = norm_den == 23'h0 ? 39'h0
                                              : norm_num / 39'(norm_den);
   wire [15:0]   norm     = |norm_q[38:16] ? REC_FULL : norm_q[15:0];

   wire          over1    = norm > thr1_ff;
   wire          over2    = norm > thr2_ff;
   wire          under1   = norm < thr1_ff;
   wire          under2   = norm < thr2_ff;
   wire          nxt_al1  = ctrl_ff[CTRL_DIR1] ? under1 : over1;
   wire          nxt_al2  = ctrl_ff[CTRL_DIR2] ? under2 : over2;

   wire [15:0]   rec_base = ctrl_ff[CTRL_VOLT] ? REC_0V : REC_4MA;
   wire [15:0]   rec_span = REC_FULL - rec_base;
   wire [15:0]   rng      = range_ff == 16'h0 ? 16'h1 : range_ff;
   // the fresh result on leaving compare
   wire [15:0]   res_now  = state_ff == ST_COMPARE ? norm : result_ff;
   wire [15:0]   res_cl   = res_now > rng ? rng : res_now;
   wire [31:0]   rec_prod = 32'(res_cl) * 32'(rec_span);
   wire [31:0]   rec_q    = rec_prod / 32'(rng);
   wire [15:0]   rec_lin  = rec_base + rec_q[15:0];
   wire          hold_zero = state_ff inside {ST_SELFTEST, ST_WARMUP,
                                              ST_ZERO};

   logic         al1_ff;
   logic         al2_ff;
   logic [15:0]  rec_ff;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         result_ff   <= 16'h0;
         have_res_ff <= 1'b0;
         al1_ff      <= 1'b0;
         al2_ff      <= 1'b0;
      end
      else if (state_ff == ST_COMPARE)
      begin
         result_ff   <= norm;
         have_res_ff <= 1'b1;
         al1_ff      <= nxt_al1;
         al2_ff      <= nxt_al2;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         rec_ff <= REC_4MA;
      else if (hold_zero)
         rec_ff <= rec_base;
      else if (enter_purge && (have_res_ff || state_ff == ST_COMPARE))
         rec_ff <= rec_lin;
   end

   ////////////////////////////////////////////////////////////////////////////
   // ready, pump, fault alarm

   logic         pump_ff;
   logic         falarm_ff;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ready_ff  <= 1'b0;
         pump_ff   <= 1'b0;
         falarm_ff <= 1'b0;
      end
      else
      begin
         if (enter_halt)
            ready_ff <= 1'b0;
         else if (enter_purge)
            ready_ff <= 1'b1;
         pump_ff   <= nxt_state == ST_PURGE;
         // polarity bit selects normally open or normally closed
         falarm_ff <= (nxt_state == ST_HALT) ^ ctrl_ff[CTRL_FNC];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // uart transmitter, one 8n1 frame per failure

   logic [9:0]   tx_sh_ff;
   logic [3:0]   tx_bits_ff;
   logic [15:0]  tx_div_ff;
   logic         tx_ff;

   wire          baud_tick = tx_div_ff == 16'(BAUD_DIV - 1);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         tx_sh_ff   <= 10'h3ff;
         tx_bits_ff <= 4'h0;
         tx_div_ff  <= 16'h0;
         tx_ff      <= 1'b1;
      end
      else if (enter_halt)
      begin
         tx_sh_ff   <= {1'b1, fault_code, 1'b0};
         tx_bits_ff <= UART_BITS;
         tx_div_ff  <= 16'h0;
      end
      else if (tx_bits_ff != 4'h0)
      begin
         tx_ff     <= tx_sh_ff[0];
         tx_div_ff <= baud_tick ? 16'h0 : tx_div_ff + 16'h1;
         if (baud_tick)
         begin
            tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
            tx_bits_ff <= tx_bits_ff - 4'h1;
         end
      end
      else
         tx_ff <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus read path

   wire [31:0]   status_w = {8'h0, code_ff, 2'h0, ztry_ff,
                             3'h0, ready_ff, state_ff};
   wire [31:0]   rd_mux =
      wb_adr_i == OFS_CTRL   ? {27'h0, ctrl_ff} :
      wb_adr_i == OFS_PURGE  ? purge_ff :
      wb_adr_i == OFS_SETTLE ? settle_ff :
      wb_adr_i == OFS_THR1   ? {16'h0, thr1_ff} :
      wb_adr_i == OFS_THR2   ? {16'h0, thr2_ff} :
      wb_adr_i == OFS_RANGE  ? {16'h0, range_ff} :
      wb_adr_i == OFS_ZTOL   ? {16'h0, ztol_ff} :
      wb_adr_i == OFS_STATUS ? status_w :
      wb_adr_i == OFS_RESULT ? {16'h0, result_ff} :
                               32'h0;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h0;
      end
      else
      begin
         ack_ff  <= bus_req;
         rdat_ff <= bus_req ? rd_mux : 32'h0;
      end
   end

   assign wb_ack_o    = ack_ff;
   assign wb_dat_o    = rdat_ff;
   assign unit_ready  = ready_ff;
   assign alarm1      = al1_ff;
   assign alarm2      = al2_ff;
   assign fault_alarm = falarm_ff;
   assign pump_on     = pump_ff;
   assign rec_value   = rec_ff;
   assign uart_tx     = tx_ff;

endmodule // gsf_top

// ---- src/gsf_pkg.sv ----
// constants, types and register map of the gas sensor cycle sequencer
package gsf_pkg;
   // clock and cycle timing
   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned PURGE_S      = 5;
   localparam int unsigned SETTLE_S     = 3;
   localparam int unsigned PURGE_CYC    = PURGE_S * CLK_HZ;
   localparam int unsigned SETTLE_CYC   = SETTLE_S * CLK_HZ;
   localparam int unsigned BAUD         = 115_200;
   localparam int unsigned BAUD_DIV     = CLK_HZ / BAUD;
   localparam logic [3:0]  UART_BITS    = 4'ha;
   // averaging and zero adjustment
   localparam int unsigned AVG_LOG2     = 6;
   localparam logic [5:0]  AVG_LAST     = 6'h3f;
   localparam logic [5:0]  ZERO_NEED    = 6'h08;
   localparam logic [5:0]  ZERO_TRIES   = 6'h32;
   // temperature limits in degrees celsius, pressure in mbar
   localparam logic signed [7:0] AMB_MIN_C  = 8'sh0a;
   localparam logic signed [7:0] AMB_MAX_C  = 8'sh28;
   localparam logic signed [7:0] CELL_MAX_C = 8'sh37;
   localparam logic [11:0] T_REF_K10    = 12'haab;
   localparam logic [10:0] P_REF_MBAR   = 11'h3f5;
   // failure characters
   localparam logic [7:0]  CODE_NONE    = 8'h00;
   localparam logic [7:0]  CODE_B       = 8'h42;
   localparam logic [7:0]  CODE_C       = 8'h43;
   localparam logic [7:0]  CODE_D       = 8'h44;
   localparam logic [7:0]  CODE_E       = 8'h45;
   localparam logic [7:0]  CODE_I       = 8'h49;
   localparam logic [7:0]  CODE_L       = 8'h4c;
   // recorder output codes, 4 ma is one fifth of the 20 ma span
   localparam logic [15:0] REC_FULL     = 16'hffff;
   localparam logic [15:0] REC_4MA      = 16'h3333;
   localparam logic [15:0] REC_0V       = 16'h0000;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_PURGE    = 8'h04;
   localparam logic [7:0]  OFS_SETTLE   = 8'h08;
   localparam logic [7:0]  OFS_THR1     = 8'h0c;
   localparam logic [7:0]  OFS_THR2     = 8'h10;
   localparam logic [7:0]  OFS_RANGE    = 8'h14;
   localparam logic [7:0]  OFS_ZTOL     = 8'h18;
   localparam logic [7:0]  OFS_STATUS   = 8'h1c;
   localparam logic [7:0]  OFS_RESULT   = 8'h20;
   // control bits and reset values
   localparam int unsigned CTRL_EXT     = 0;
   localparam int unsigned CTRL_DIR1    = 1;
   localparam int unsigned CTRL_DIR2    = 2;
   localparam int unsigned CTRL_FNC     = 3;
   localparam int unsigned CTRL_VOLT    = 4;
   localparam logic [4:0]  CTRL_RST     = 5'h00;
   localparam logic [15:0] THR_RST      = 16'hffff;
   localparam logic [15:0] RANGE_RST    = 16'hffff;
   localparam logic [15:0] ZTOL_RST     = 16'h0010;

   typedef enum logic [3:0] {
      ST_SELFTEST = 4'h0,
      ST_WARMUP   = 4'h1,
      ST_ZERO     = 4'h2,
      ST_STANDBY  = 4'h3,
      ST_PURGE    = 4'h4,
      ST_SETTLE   = 4'h5,
      ST_MEASURE  = 4'h6,
      ST_COMPARE  = 4'h7,
      ST_HALT     = 4'h8
   } gsf_state_t;

   typedef struct packed {
      logic signed [7:0] amb_c;
      logic signed [7:0] cell_c;
      logic [11:0]       gas_k10;
      logic [10:0]       pres_mbar;
   } gsf_env_t;

   typedef struct packed {
      logic cfg_ok;
      logic ir_power_ok;
      logic chopper_ok;
      logic warmup_done;
   } gsf_health_t;
endpackage

// ---- tb/gsf_monitor.sv ----
// checker: port level assertions for the gas sensor sequencer
`timescale 1ns/100ps
module gsf_monitor
   import gsf_pkg::*;
#(
   parameter int unsigned PURGE_DEF = PURGE_CYC
)(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_n,
   // bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   // sensor and controller side
   input wire logic        sample_vld,
   input wire logic        unit_ready,
   input wire logic        alarm1,
   input wire logic        alarm2,
   input wire logic        fault_alarm,
   input wire logic        pump_on,
   input wire logic [15:0] rec_value,
   input wire logic        uart_tx
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   // purge length counter, cleared whenever the pump is off
   logic [31:0] pump_cnt_ff;
   logic [31:0] nxt_pump_cnt;
   assign nxt_pump_cnt = pump_on ? pump_cnt_ff + 32'h1 : 32'h0;
   always_ff @(posedge sys_clk)
      pump_cnt_ff <= rst_n ? nxt_pump_cnt : 32'h0;
   ////////////////////////////////////////////////////////////////////////
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
   sequence s_start_bit; !uart_tx [*8]; endsequence
   property p_ack; s_req |=> s_ack_pulse; endproperty
   property p_purge_len;
      $fell(pump_on) && !fault_alarm |-> pump_cnt_ff == PURGE_DEF + 1;
   endproperty
   property p_ready_pump; $rose(pump_on) |-> unit_ready; endproperty
   property p_halt_out; fault_alarm |-> !pump_on && !unit_ready; endproperty
   property p_halt_stay; fault_alarm |=> fault_alarm; endproperty
   property p_uart_start; $rose(fault_alarm) |=> s_start_bit; endproperty
   property p_rec_upd; $changed(rec_value) |-> $rose(pump_on); endproperty
   // base level assumes the current output variant, as the bench runs it
   property p_rec_base;
      !unit_ready && !fault_alarm |-> rec_value == REC_4MA;
   endproperty
   property p_alarm_time;
      $changed(alarm1) || $changed(alarm2)
         |-> $past(sample_vld, 2) || $past(sample_vld, 3);
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   a_purge_len: assert property (p_purge_len)
      else $error("purge length wrong");
   a_ready_pump: assert property (p_ready_pump)
      else $error("pump ran while not ready");
   a_halt_out: assert property (p_halt_out)
      else $error("activity while halted");
   a_halt_stay: assert property (p_halt_stay)
      else $error("fault alarm released");
   a_uart_start: assert property (p_uart_start)
      else $error("no start bit after fault");
   a_rec_upd: assert property (p_rec_upd)
      else $error("recorder moved outside purge start");
   a_rec_base: assert property (p_rec_base)
      else $error("recorder not at base level");
   a_alarm_time: assert property (p_alarm_time)
      else $error("alarm moved without a result");
endmodule // gsf_monitor

bind gsf_top gsf_monitor #(.PURGE_DEF(PURGE_DEF)) gsf_monitor_inst (
   .sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sample_vld,
   .unit_ready, .alarm1, .alarm2, .fault_alarm, .pump_on, .rec_value,
   .uart_tx
);

// ---- tb/gsf_plc_model.sv ----
// plant controller model: start and measurement request levels
`timescale 1ns/100ps
module gsf_plc_model
   import gsf_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // bench commands
   input  wire logic want_meas,
   input  wire logic skip_start,
   // controller outputs
   output logic      start,
   output logic      meas_req,
   output logic      zero_req
);
   logic start_ff;
   logic meas_ff;
   // start leads the request by a cycle so no request is lost
   always_ff @(posedge sys_clk)
   begin
      start_ff <= rst_n && want_meas && !skip_start;
      meas_ff  <= rst_n && want_meas && (start_ff || skip_start);
   end
   assign start    = start_ff;
   assign meas_req = meas_ff;
   // zero adjustment only at start-up here
   assign zero_req = 1'b0;
endmodule // gsf_plc_model

// ---- tb/tb.sv ----
// testbench: scoreboard checks of the gas sensor sequencer
`timescale 1ns/100ps
module tb;
   import gsf_pkg::*;
   localparam int unsigned PURGE  = 20;
   localparam int unsigned SETTLE = 10;
   logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic        sample_vld, start, meas_req, zero_req, unit_ready;
   logic        alarm1, alarm2, fault_alarm, pump_on, uart_tx;
   logic        want_meas, skip_start;
   logic [15:0] sample, rec_value;
   gsf_env_t    env;
   gsf_health_t health;
   int          n_mismatch, check_count, cyc_cnt, off, s, l;
   longint      res, exp_rec;
   logic [7:0]  code [6] = '{CODE_L, CODE_B, CODE_C, CODE_D, CODE_I, CODE_E};

   gsf_top #(.PURGE_DEF(PURGE), .SETTLE_DEF(SETTLE)) gsf_top_inst (
      .sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sample_vld, .sample,
      .env, .health, .start, .meas_req, .zero_req, .unit_ready, .alarm1,
      .alarm2, .fault_alarm, .pump_on, .rec_value, .uart_tx);
   gsf_plc_model gsf_plc_model_inst (.sys_clk, .rst_n, .want_meas,
      .skip_start, .start, .meas_req, .zero_req);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (n_mismatch == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do
         @(posedge sys_clk);
      while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wait_for(ref logic sig, input logic v);
      while (sig !== v)
         @(posedge sys_clk);
   endtask
   // back to back strobes, valid held high between samples
   task automatic feed(input int n, input int lo, input int hi,
                       output int sum, output int last);
      sum = 0;
      repeat (n)
      begin
         @(posedge sys_clk);
         last = $urandom_range(hi, lo);
         sample <= last[15:0];
         sample_vld <= 1'b1;
         sum += last;
      end
      @(posedge sys_clk);
      sample_vld <= 1'b0;
   endtask
   task automatic uart_chk(input logic [7:0] exp);
      logic [7:0] got;
      wait_for(uart_tx, 1'b0);
      repeat (BAUD_DIV / 2) @(posedge sys_clk);
      chk(uart_tx, 0);
      for (int b = 0; b < 8; b++)
      begin
         repeat (BAUD_DIV) @(posedge sys_clk);
         got[b] = uart_tx;
      end
      repeat (BAUD_DIV) @(posedge sys_clk);
      chk(uart_tx, 1);
      chk(got, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 70000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   initial
   begin
      {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, sample_vld} = 5'h00;
      {wb_adr_i, wb_sel_i, wb_dat_i, sample} = '0;
      {want_meas, skip_start, n_mismatch, check_count, cyc_cnt} = '0;
      health = '1;
      env.amb_c = AMB_MIN_C;
      env.cell_c = CELL_MAX_C;
      env.gas_k10 = 12'hb9a;
      env.pres_mbar = 11'h3a2;
      void'($urandom(32'h7f9e));
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk(rec_value, REC_4MA);
      chk(uart_tx, 1);
      wb(1'b1, OFS_CTRL, 32'h1, rd);
      wb(1'b1, OFS_STATUS, '1, rd);
      wb(1'b1, 8'h40, '1, rd);
      wb(1'b0, OFS_THR1, 0, rd);
      chk(rd, THR_RST);
      wb(1'b0, OFS_ZTOL, 0, rd);
      chk(rd, ZTOL_RST);
      wb(1'b0, 8'h40, 0, rd);
      chk(rd, 0);
      wb(1'b0, OFS_STATUS, 0, rd);
      chk(rd[3:0], ST_ZERO);
      wb(1'b1, OFS_THR1, 32'd100, rd);
      // zero hits, the last one fixes the offset
      feed(7, 0, ZTOL_RST, s, off);
      feed(1, 5, 5, s, off);
      repeat (4) @(posedge sys_clk);
      wb(1'b0, OFS_STATUS, 0, rd);
      chk(rd[3:0], ST_STANDBY);
      chk(unit_ready, 0);
      // requests without start must be ignored
      skip_start <= 1'b1;
      want_meas <= 1'b1;
      repeat (40) @(posedge sys_clk);
      chk(pump_on, 0);
      skip_start <= 1'b0;
      exp_rec = REC_4MA;
      for (int k = 0; k < 3; k++)
      begin
         wait_for(pump_on, 1'b1);
         chk(rec_value, exp_rec);
         chk(unit_ready, 1);
         wait_for(pump_on, 1'b0);
         repeat (SETTLE + 3) @(posedge sys_clk);
         if (k == 1)
            feed(64, 0, 0, s, l);
         else
            feed(64, 16'h100, 16'h8000, s, l);
         res = s / 64 - off;
         if (res < 0)
            res = 0;
         res = res * env.gas_k10 * P_REF_MBAR / (T_REF_K10 * env.pres_mbar);
         exp_rec = REC_4MA + res * (REC_FULL - REC_4MA) / RANGE_RST;
         repeat (3) @(posedge sys_clk);
         chk(alarm1, res > 100);
         chk(alarm2, 0);
         wb(1'b0, OFS_RESULT, 0, rd);
         chk(rd, res);
      end
      want_meas <= 1'b0;
      // one failure per fresh start-up
      for (int i = 0; i < 6; i++)
      begin
         health <= '1;
         env.amb_c <= AMB_MIN_C;
         env.cell_c <= CELL_MAX_C;
         rst_n <= 1'b0;
         repeat (6) @(posedge sys_clk);
         rst_n <= 1'b1;
         case (i)
            0: health.cfg_ok <= 1'b0;
            1: health.ir_power_ok <= 1'b0;
            2: health.chopper_ok <= 1'b0;
            3: env.amb_c <= AMB_MIN_C - 8'sh01;
            4: env.cell_c <= CELL_MAX_C + 8'sh01;
            default: ;
         endcase
         repeat (5) @(posedge sys_clk);
         if (i == 5)
            feed(50, 16'h20, 16'hff, s, l);
         wait_for(fault_alarm, 1'b1);
         uart_chk(code[i]);
         wb(1'b0, OFS_STATUS, 0, rd);
         chk(rd[23:16], code[i]);
         chk(rd[3:0], ST_HALT);
      end
      stop_test();
   end
endmodule // tb
